// >>> dv/asbp_ctrl_monitor.sv
// Pin-level assertions for the byte memory controller.
`timescale 1ns/10ps
module asbp_ctrl_monitor
(
	// Clock and reset.
	input wire core_clk_in,
	input wire rst_in,
	// Watched ports.
	input wire req_valid_in,
	input wire req_write_in,
	input wire req_ready_out,
	input wire rsp_valid_out,
	input wire [20:0] mem_addr_out,
	input wire first_select_n_out,
	input wire second_select_hi_out,
	input wire output_drive_n_out,
	input wire write_strobe_n_out,
	input wire [7:0] mem_data_oe_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence take_rd;
		req_valid_in && req_ready_out && !req_write_in;
	endsequence
	sequence wr_pulse;
		!write_strobe_n_out [*3];
	endsequence
	a_select_pair: assert property (second_select_hi_out == !first_select_n_out)
		else $error("select pins disagree");
	a_read_strobe_high: assert property (!output_drive_n_out |-> write_strobe_n_out)
		else $error("strobe low while memory drives");
	a_addr_held_sel: assert property (!first_select_n_out && !$past(first_select_n_out) |-> $stable(mem_addr_out))
		else $error("address moved while selected");
	a_write_in_sel: assert property (!write_strobe_n_out |-> !first_select_n_out && mem_data_oe_out == 8'hff)
		else $error("strobe outside select or bus undriven");
	a_strobe_width: assert property ($fell(write_strobe_n_out) |-> wr_pulse)
		else $error("write strobe too short");
	a_no_joint_end: assert property ($rose(write_strobe_n_out) |-> !first_select_n_out)
		else $error("select dropped with strobe");
	a_write_drive_off: assert property (!write_strobe_n_out |-> output_drive_n_out)
		else $error("output drive on during write");
	a_read_answer: assert property (take_rd |-> ##7 rsp_valid_out)
		else $error("read answer not on time");
endmodule // asbp_ctrl_monitor
bind asbp_ctrl asbp_ctrl_monitor i_asbp_ctrl_monitor (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_ready_out(req_ready_out),
	.rsp_valid_out(rsp_valid_out), .mem_addr_out(mem_addr_out), .first_select_n_out(first_select_n_out),
	.second_select_hi_out(second_select_hi_out), .output_drive_n_out(output_drive_n_out),
	.write_strobe_n_out(write_strobe_n_out), .mem_data_oe_out(mem_data_oe_out));

// >>> dv/asbp_ctrl_tb_top.sv
// Self-checking bench for the byte memory controller.
`timescale 1ns/10ps
module asbp_ctrl_tb_top;
	reg core_clk_in = 1'b0;
	reg rst_in = 1'b1;
	reg req_valid_in = 1'b0;
	reg req_write_in = 1'b0;
	reg [20:0] req_addr_in = 21'h00_0000;
	reg [7:0] req_wdata_in = 8'h00;
	wire req_ready_out, rsp_valid_out, first_select_n_out, second_select_hi_out, output_drive_n_out;
	wire write_strobe_n_out, model_drv;
	wire [20:0] mem_addr_out;
	wire [7:0] rsp_rdata_out, mem_data_out, mem_data_oe_out, model_q;
	wire [7:0] mem_data_in = mem_data_oe_out[0] ? mem_data_out : model_q;
	integer n_errors = 0;
	integer num_checks = 0;
	integer cyc = 0;
	always #2.5 core_clk_in = ~core_clk_in;
	asbp_ctrl i_asbp_ctrl (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
		.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
		.mem_addr_out(mem_addr_out), .first_select_n_out(first_select_n_out),
		.second_select_hi_out(second_select_hi_out), .output_drive_n_out(output_drive_n_out),
		.write_strobe_n_out(write_strobe_n_out), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
		.mem_data_oe_out(mem_data_oe_out));
	asbp_sram_model i_asbp_sram_model (.addr_in(mem_addr_out), .first_select_n_in(first_select_n_out),
		.second_select_hi_in(second_select_hi_out), .output_drive_n_in(output_drive_n_out),
		.write_strobe_n_in(write_strobe_n_out), .bus_in(mem_data_in), .data_out(model_q), .drive_out(model_drv));
	task chk(input [8*8-1:0] what, input [20:0] seen, input [20:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task summarize;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	always @(posedge core_clk_in)
	begin
		cyc = cyc + 1;
		if (cyc == 2000)
		begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	task op(input w, input [20:0] a, input [7:0] d);
		integer i;
	begin
		@(negedge core_clk_in);
		chk("ready", req_ready_out, 1'b1);
		req_valid_in = 1'b1;
		req_write_in = w;
		req_addr_in = a;
		req_wdata_in = d;
		@(negedge core_clk_in);
		req_valid_in = 1'b0;
		if (w)
			chk("wrfloat", model_drv, 1'b0);
		// The pulse launched at the sixth edge after the take is sampled at the seventh.
		i = 1;
		while (!w && !rsp_valid_out && i < 12)
		begin
			@(negedge core_clk_in);
			i = i + 1;
		end
		if (!w)
		begin
			chk("latency", i, 7);
			chk("rdata", rsp_rdata_out, d);
		end
		i = 0;
		while (!req_ready_out && i < 12)
		begin
			@(negedge core_clk_in);
			i = i + 1;
		end
	end
	endtask
	task t_idle;
	begin
		chk("idle", {first_select_n_out, second_select_hi_out, output_drive_n_out, write_strobe_n_out}, 4'hb);
		chk("float", {model_drv, mem_data_oe_out}, 9'h000);
		$display("test idle done");
	end
	endtask
	task t_edges;
	begin
		op(1'b1, 21'h00_0000, 8'ha5);
		op(1'b1, 21'h1f_ffff, 8'h5a);
		op(1'b0, 21'h1f_ffff, 8'h5a);
		op(1'b0, 21'h00_0000, 8'ha5);
		$display("test edges done");
	end
	endtask
	task t_over;
	begin
		op(1'b1, 21'h0a_aaaa, 8'h3c);
		op(1'b1, 21'h0a_aaaa, 8'hc3);
		op(1'b0, 21'h0a_aaaa, 8'hc3);
		op(1'b0, 21'h00_0000, 8'ha5);
		t_idle;
		$display("test overwrite done");
	end
	endtask
	initial
	begin
		repeat (10) @(negedge core_clk_in);
		rst_in = 1'b0;
		t_idle;
		t_edges;
		t_over;
		summarize;
	end
endmodule // asbp_ctrl_tb_top

// >>> dv/asbp_sram_model.sv
// Behavioural byte-wide static memory on the controller pins.
`timescale 1ns/10ps
module asbp_sram_model
(
	// Memory pins.
	input wire [20:0] addr_in,
	input wire first_select_n_in,
	input wire second_select_hi_in,
	input wire output_drive_n_in,
	input wire write_strobe_n_in,
	input wire [7:0] bus_in,
	output wire [7:0] data_out,
	output wire drive_out
);
	reg [7:0] mem [0:2097151];
	wire sel = !first_select_n_in && second_select_hi_in;
	// A write is open while the combined select and the strobe are both active.
	wire wr_open = sel && !write_strobe_n_in;
	assign drive_out = sel && !output_drive_n_in && write_strobe_n_in;
	// A floating bus shows inverted data so a sample taken too late cannot pass.
	assign data_out = drive_out ? mem[addr_in] : ~mem[addr_in];
	// Storing only at the closing edge keeps a same-step address change at write start from hitting the old location.
	always @(negedge wr_open)
		mem[addr_in] <= bus_in;
endmodule // asbp_sram_model

// >>> hw/asbp_ctrl.v
// Host controller that drives an asynchronous byte-wide static memory through its pins.
//
// Summary of operation
// - Each read selects the memory and drops the select again once the byte is sampled.
// - Strobe stays high through every read cycle.
// - Address is valid no later than the combined select asserts.
// - Write strobe lasts at least float delay plus data setup time.
// - Write opens with strobe and select active; data timed to the ending edge.
`timescale 1ns/10ps
`include "asbp_map.vh"
module asbp_ctrl
(
	// Clock and reset.
	input wire core_clk_in,
	input wire rst_in,
	// User request side.
	input wire req_valid_in,
	input wire req_write_in,
	input wire [`ASBP_ADDR_W-1:0] req_addr_in,
	input wire [`ASBP_DATA_W-1:0] req_wdata_in,
	output wire req_ready_out,
	// User answer side.
	output wire rsp_valid_out,
	output wire [`ASBP_DATA_W-1:0] rsp_rdata_out,
	// Memory pins.
	output wire [`ASBP_ADDR_W-1:0] mem_addr_out,
	output wire first_select_n_out,
	output wire second_select_hi_out,
	output wire output_drive_n_out,
	output wire write_strobe_n_out,
	input wire [`ASBP_DATA_W-1:0] mem_data_in,
	output wire [`ASBP_DATA_W-1:0] mem_data_out,
	output wire [`ASBP_DATA_W-1:0] mem_data_oe_out
);
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_READ = 5'b00010;
	localparam [4:0] ST_SAMPLE = 5'b00100;
	localparam [4:0] ST_WRITE = 5'b01000;
	localparam [4:0] ST_FLOAT = 5'b10000;
	// The cycle macros are integer arithmetic; the counter keeps only its own width.
	localparam integer RD_CYC_I = `ASBP_RD_CYC;
	localparam integer WR_CYC_I = `ASBP_WR_PULSE_CYC;
	localparam integer FL_CYC_I = `ASBP_FLOAT_CYC;
	localparam [`ASBP_CNT_W-1:0] RD_CYC = RD_CYC_I[`ASBP_CNT_W-1:0];
	localparam [`ASBP_CNT_W-1:0] WR_CYC = WR_CYC_I[`ASBP_CNT_W-1:0];
	localparam [`ASBP_CNT_W-1:0] FL_CYC = FL_CYC_I[`ASBP_CNT_W-1:0];
	// Three extra edges cover the synchroniser delay on the returned byte.
	localparam [`ASBP_CNT_W-1:0] SYNC_CYC = 4'h3;

	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg [`ASBP_CNT_W-1:0] cnt_reg;
	reg [`ASBP_CNT_W-1:0] cnt_next;
	reg [`ASBP_ADDR_W-1:0] addr_reg;
	reg [`ASBP_ADDR_W-1:0] addr_next;
	reg [`ASBP_DATA_W-1:0] wdata_reg;
	reg [`ASBP_DATA_W-1:0] wdata_next;
	reg [`ASBP_DATA_W-1:0] rdata_reg;
	reg [`ASBP_DATA_W-1:0] rdata_next;
	reg rsp_reg;
	reg rsp_next;
	reg sel_n_reg;
	reg sel_n_next;
	reg oe_n_reg;
	reg oe_n_next;
	reg we_n_reg;
	reg we_n_next;
	reg drive_reg;
	reg drive_next;
	wire [`ASBP_DATA_W-1:0] data_sync;

	genvar gi;
	generate
		for (gi = 0; gi < `ASBP_DATA_W; gi = gi + 1)
		begin : g_sync
			asbp_sync3 u_sync
			(
				.core_clk_in(core_clk_in),
				.rst_in(rst_in),
				.pin_in(mem_data_in[gi]),
				.level_out(data_sync[gi])
			);
		end
	endgenerate

	function cnt_done;
		input [`ASBP_CNT_W-1:0] c;
		begin
			cnt_done = (c == `ASBP_CNT_ZERO);
		end
	endfunction

	assign req_ready_out = (state_reg == ST_IDLE);

	always @*
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		rsp_next = 1'b0;
		sel_n_next = sel_n_reg;
		oe_n_next = oe_n_reg;
		we_n_next = we_n_reg;
		drive_next = drive_reg;
		if (!cnt_done(cnt_reg))
			cnt_next = cnt_reg - 4'h1;
		case (state_reg)
			ST_IDLE:
			begin
				if (req_valid_in)
				begin
					// The address and select change on the same edge, so address is never late.
					addr_next = req_addr_in;
					sel_n_next = 1'b0;
					if (req_write_in)
					begin
						wdata_next = req_wdata_in;
						oe_n_next = 1'b1;
						we_n_next = 1'b0;
						drive_next = 1'b1;
						cnt_next = WR_CYC - 4'h1;
						state_next = ST_WRITE;
					end
					else
					begin
						oe_n_next = 1'b0;
						we_n_next = 1'b1;
						cnt_next = RD_CYC + SYNC_CYC - 4'h1;
						state_next = ST_READ;
					end
				end
			end
			ST_READ:
			begin
				// Select and address both hold steady for the whole read; neither moves until the count ends.
				if (cnt_done(cnt_reg))
					state_next = ST_SAMPLE;
			end
			ST_SAMPLE:
			begin
				rdata_next = data_sync;
				rsp_next = 1'b1;
				oe_n_next = 1'b1;
				sel_n_next = 1'b1;
				cnt_next = FL_CYC - 4'h1;
				state_next = ST_FLOAT;
			end
			ST_WRITE:
			begin
				if (cnt_done(cnt_reg))
				begin
					// The strobe edge ends the write; data and address hold one more cycle.
					we_n_next = 1'b1;
					cnt_next = FL_CYC - 4'h1;
					state_next = ST_FLOAT;
				end
			end
			ST_FLOAT:
			begin
				if (we_n_reg && drive_reg)
				begin
					// Select drops after the strobe so the bus is never fought over.
					drive_next = 1'b0;
					sel_n_next = 1'b1;
				end
				if (cnt_done(cnt_reg) && sel_n_reg)
					state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
				sel_n_next = 1'b1;
				oe_n_next = 1'b1;
				we_n_next = 1'b1;
				drive_next = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= `ASBP_CNT_ZERO;
			addr_reg <= `ASBP_ADDR_ZERO;
			wdata_reg <= `ASBP_DATA_ZERO;
			rdata_reg <= `ASBP_DATA_ZERO;
			rsp_reg <= 1'b0;
			sel_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			drive_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			rsp_reg <= rsp_next;
			sel_n_reg <= sel_n_next;
			oe_n_reg <= oe_n_next;
			we_n_reg <= we_n_next;
			drive_reg <= drive_next;
		end
	end

	assign rsp_valid_out = rsp_reg;
	assign rsp_rdata_out = rdata_reg;
	assign mem_addr_out = addr_reg;
	// Both selects follow one register so they always agree.
	assign first_select_n_out = sel_n_reg;
	assign second_select_hi_out = ~sel_n_reg;
	assign output_drive_n_out = oe_n_reg;
	assign write_strobe_n_out = we_n_reg;
	assign mem_data_out = wdata_reg;
	assign mem_data_oe_out = {`ASBP_DATA_W{drive_reg}};
endmodule // asbp_ctrl

// >>> hw/asbp_sync3.v
// Three-stage synchroniser with agreement filter for one pin input bit.
`timescale 1ns/10ps
`include "asbp_map.vh"
module asbp_sync3
(
	// Clock and reset.
	input wire core_clk_in,
	input wire rst_in,
	// Pin side and filtered result.
	input wire pin_in,
	output wire level_out
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg level_reg;
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end
	end
	assign level_out = level_reg;
endmodule // asbp_sync3

// >>> inc/asbp_map.vh
// Constants for the asynchronous byte memory access controller.
`ifndef ASBP_MAP_VH
`define ASBP_MAP_VH
`define ASBP_ADDR_W 21
`define ASBP_DATA_W 8
// Pin timing figures in picoseconds.
`define ASBP_CLK_PS 5000
`define ASBP_T_RC_PS 10000
`define ASBP_T_AA_PS 10000
`define ASBP_T_WC_PS 10000
`define ASBP_T_PWE_PS 7000
`define ASBP_T_HZWE_PS 5000
`define ASBP_T_SD_PS 5500
`define ASBP_T_HZCE_PS 5000
// Cycle counts: least times round up, at least one cycle.
`define ASBP_CEIL(t) ((((t) + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS) < 1 ? 1 : \
	(((t) + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS))
`define ASBP_RD_CYC `ASBP_CEIL(`ASBP_T_AA_PS)
`define ASBP_WR_PULSE_CYC `ASBP_CEIL(`ASBP_T_HZWE_PS + `ASBP_T_SD_PS)
`define ASBP_FLOAT_CYC `ASBP_CEIL(`ASBP_T_HZCE_PS)
`define ASBP_CNT_W 4
`define ASBP_CNT_ZERO 4'h0
`define ASBP_DATA_ZERO 8'h00
`define ASBP_ADDR_ZERO 21'h00_0000
`endif
